// ==== include/lic_pkg.sv ====
// shared constants for the line interface control block
package lic_pkg;
   // register offsets
   localparam logic [7:0] LIC_OFS_IMPEDANCE = 8'h02;
   localparam logic [7:0] LIC_OFS_TX_CFG_A = 8'h04;
   localparam logic [7:0] LIC_OFS_TX_CFG_B = 8'h05;
   localparam logic [7:0] LIC_OFS_RX_CFG_B = 8'h0a;
   localparam logic [7:0] LIC_OFS_RX_CFG_C = 8'h0b;
   localparam logic [7:0] LIC_OFS_IRQ_MASK = 8'h12;
   localparam logic [7:0] LIC_OFS_EDGE_SEL = 8'h15;
   localparam logic [7:0] LIC_OFS_STATUS_A = 8'h16;
   localparam logic [7:0] LIC_OFS_STATUS_B = 8'h17;
   localparam logic [7:0] LIC_OFS_IRQ_STAT_A = 8'h18;
   // field positions
   localparam int LIC_TX_TERM_LSB = 0;
   localparam int LIC_RX_TERM_LSB = 3;
   localparam int LIC_TERM_EXT_BIT = 2;
   localparam int LIC_TX_OFF_BIT = 4;
   localparam int LIC_DRV_HIZ_BIT = 5;
   localparam int LIC_LONG_HAUL_BIT = 5;
   localparam int LIC_EQ_ENABLE_BIT = 6;
   localparam int LIC_MON_GAIN_LSB = 0;
   localparam int LIC_OBS_WIN_LSB = 2;
   localparam int LIC_EQ_BIT = 7;
   localparam int LIC_LOSS_W = 5;
   // reset values
   localparam logic [7:0] LIC_RST_ZERO = 8'h00;
   localparam logic [7:0] LIC_RST_RX_CFG_C = 8'h08;
   // hardware-mode encodings
   localparam logic [1:0] LIC_TXFN_OFF = 2'h3;
   localparam logic [1:0] LIC_GAIN_26DB = 2'h2;
   localparam logic [1:0] LIC_GAIN_0DB = 2'h0;
   // observation periods in symbols
   localparam logic [8:0] LIC_OBS_32 = 9'h020;
   localparam logic [8:0] LIC_OBS_64 = 9'h040;
   localparam logic [8:0] LIC_OBS_128 = 9'h080;
   localparam logic [8:0] LIC_OBS_256 = 9'h100;
   // synchronised pin vector width
   localparam int LIC_SYNC_W = 19;
endpackage

// ==== hw/lic_sync.sv ====
// two-flop synchroniser for a vector of independent level inputs
`timescale 1ns/10ps
`default_nettype none
module lic_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // levels
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_r;

   // meta_r feeds only the second stage; each bit is an unrelated level
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_r <= '0;
         o_q <= '0;
      end
      else
      begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== hw/lic_line_ctrl.sv ====
// per-channel line interface control: termination, driver state, equaliser status
// Notes on behaviour
// - transmit field top bit 0 gives internal match, low bits pick impedance; 1 disables
// - receive field top bit 0 gives internal match at codes 0-3; 1 disables
// - hardware pin low: internal both; high: external, except T1/J1 transmit stays internal
// - global pin, or channel bit outside hardware mode, puts drivers high impedance; transmit logic runs on
// - drivers also float on master clock loss, on transmit clock loss unless remote loopback or mclk pattern, on power-down and after any reset
// - transmit power-down bit powers down transmit and floats the drivers
// - hardware transmit function pins at 11 power down the transmit path
// - hardware internal mode: four profile pins select the transmit setting
// - two-bit gain field selects 0, 22, 26 or 32 dB monitor boost
// - hardware gain pin low gives 0 dB, high gives 26 dB
// - equaliser runs while its enable bit is 1, or in hardware mode while the haul pin is high
// - range flag reads 1 while the equaliser is out of range
// - edge select 1: any range flag change sets the interrupt flag unless masked
// - edge select 0: only a rising range flag sets the interrupt flag
// - reading the interrupt flag clears it
// - two-bit window field picks 32 to 256 symbols; 128 after reset
// - five-bit read-only field reports cable loss in about 2 dB steps
// - hardware haul pin picks short or long haul receive per channel
`timescale 1ns/10ps
`default_nettype none
module lic_line_ctrl
   import lic_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_soft_reset,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // same-clock context
   input wire logic i_t1_mode,
   input wire logic i_remote_loopback,
   input wire logic i_tx_pattern_mclk,
   // hardware control pins
   input wire logic i_hw_mode,
   input wire logic i_hw_impedance_pin,
   input wire logic [3:0] i_hw_line_profile_pins,
   input wire logic [1:0] i_hw_tx_function_pins,
   input wire logic i_hw_monitor_gain_pin,
   input wire logic i_hw_haul_select_pin,
   input wire logic i_driver_hiz_ctl,
   // clock monitors and analog status
   input wire logic i_mclk_lost,
   input wire logic i_tclk_lost,
   input wire logic i_equalizer_range_in,
   input wire logic [4:0] i_cable_loss_in,
   // line-side controls
   output logic o_tx_internal_match,
   output logic [3:0] o_tx_profile,
   output logic o_rx_internal_match,
   output logic [1:0] o_rx_impedance_code,
   output logic o_tx_hiz,
   output logic o_tx_power_down,
   output logic [1:0] o_monitor_gain_sel,
   output logic o_equalizer_enable,
   output logic o_long_haul,
   output logic [8:0] o_obs_period,
   output logic o_eq_irq
);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [LIC_SYNC_W-1:0] pins_s;
   logic hw_s;
   logic imp_pin_s;
   logic [3:0] prof_s;
   logic [1:0] txfn_s;
   logic gain_pin_s;
   logic haul_s;
   logic hiz_pin_s;
   logic mclk_lost_s;
   logic tclk_lost_s;
   logic range_s;
   logic [4:0] loss_s;

   lic_sync #(
      .WIDTH(LIC_SYNC_W)
   ) u_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_d({i_hw_mode, i_hw_impedance_pin, i_hw_line_profile_pins, i_hw_tx_function_pins,
            i_hw_monitor_gain_pin, i_hw_haul_select_pin, i_driver_hiz_ctl, i_mclk_lost,
            i_tclk_lost, i_equalizer_range_in, i_cable_loss_in}),
      .o_q(pins_s)
   );

   assign {hw_s, imp_pin_s, prof_s, txfn_s, gain_pin_s, haul_s, hiz_pin_s, mclk_lost_s,
           tclk_lost_s, range_s, loss_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////
   // functions
   function automatic logic [3:0] term_to_profile(input logic [1:0] code);
      unique case (code)
         2'h0: term_to_profile = 4'h0;
         2'h1: term_to_profile = 4'h1;
         2'h2: term_to_profile = 4'h2;
         2'h3: term_to_profile = 4'h7;
      endcase
   endfunction

   function automatic logic [8:0] window_to_period(input logic [1:0] sel);
      unique case (sel)
         2'h0: window_to_period = LIC_OBS_32;
         2'h1: window_to_period = LIC_OBS_64;
         2'h2: window_to_period = LIC_OBS_128;
         2'h3: window_to_period = LIC_OBS_256;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [7:0] imp_r;
   logic [7:0] tx_cfg_a_r;
   logic [7:0] tx_cfg_b_r;
   logic [7:0] rx_cfg_b_r;
   logic [7:0] rx_cfg_c_r;
   logic [7:0] edge_sel_r;
   logic [7:0] irq_mask_r;
   logic reset_hiz_r;
   logic wr_tx_cfg_b;

   assign wr_tx_cfg_b = i_reg_wr && (i_reg_addr == LIC_OFS_TX_CFG_B);

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         imp_r <= LIC_RST_ZERO;
         tx_cfg_a_r <= LIC_RST_ZERO;
         tx_cfg_b_r <= LIC_RST_ZERO;
         rx_cfg_b_r <= LIC_RST_ZERO;
         rx_cfg_c_r <= LIC_RST_RX_CFG_C;
         edge_sel_r <= LIC_RST_ZERO;
         irq_mask_r <= LIC_RST_ZERO;
      end
      else if (i_soft_reset)
      begin
         imp_r <= LIC_RST_ZERO;
         tx_cfg_a_r <= LIC_RST_ZERO;
         tx_cfg_b_r <= LIC_RST_ZERO;
         rx_cfg_b_r <= LIC_RST_ZERO;
         rx_cfg_c_r <= LIC_RST_RX_CFG_C;
         edge_sel_r <= LIC_RST_ZERO;
         irq_mask_r <= LIC_RST_ZERO;
      end
      else if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            LIC_OFS_IMPEDANCE: imp_r <= i_reg_wdata;
            LIC_OFS_TX_CFG_A: tx_cfg_a_r <= i_reg_wdata;
            LIC_OFS_TX_CFG_B: tx_cfg_b_r <= i_reg_wdata;
            LIC_OFS_RX_CFG_B: rx_cfg_b_r <= i_reg_wdata;
            LIC_OFS_RX_CFG_C: rx_cfg_c_r <= i_reg_wdata;
            LIC_OFS_EDGE_SEL: edge_sel_r <= i_reg_wdata;
            LIC_OFS_IRQ_MASK: irq_mask_r <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // drivers stay floating after any reset until software touches the driver
   // register, or until the channel runs under pin control
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         reset_hiz_r <= 1'b1;
      else if (i_soft_reset)
         reset_hiz_r <= 1'b1;
      else if (wr_tx_cfg_b || hw_s)
         reset_hiz_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // equaliser status and interrupt flag
   logic range_d_r;
   logic equalizer_irq_flag_r;
   logic eq_set;
   logic eq_clr;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         range_d_r <= 1'b0;
      else
         range_d_r <= range_s;
   end

   always_comb
   begin
      if (edge_sel_r[LIC_EQ_BIT])
         eq_set = range_s ^ range_d_r;
      else
         eq_set = range_s & ~range_d_r;
      eq_set = eq_set & ~irq_mask_r[LIC_EQ_BIT];
   end

   assign eq_clr = i_reg_rd && (i_reg_addr == LIC_OFS_IRQ_STAT_A);

   // a set in the reading cycle survives so the event is seen on the next read
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         equalizer_irq_flag_r <= 1'b0;
      else if (i_soft_reset)
         equalizer_irq_flag_r <= 1'b0;
      else if (eq_set)
         equalizer_irq_flag_r <= 1'b1;
      else if (eq_clr)
         equalizer_irq_flag_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the read strobe
   logic [7:0] rdata_nxt;

   always_comb
   begin
      rdata_nxt = 8'h00;
      unique case (i_reg_addr)
         LIC_OFS_IMPEDANCE: rdata_nxt = imp_r;
         LIC_OFS_TX_CFG_A: rdata_nxt = tx_cfg_a_r;
         LIC_OFS_TX_CFG_B: rdata_nxt = tx_cfg_b_r;
         LIC_OFS_RX_CFG_B: rdata_nxt = rx_cfg_b_r;
         LIC_OFS_RX_CFG_C: rdata_nxt = rx_cfg_c_r;
         LIC_OFS_EDGE_SEL: rdata_nxt = edge_sel_r;
         LIC_OFS_IRQ_MASK: rdata_nxt = irq_mask_r;
         LIC_OFS_STATUS_A: rdata_nxt[LIC_EQ_BIT] = range_s;
         LIC_OFS_STATUS_B: rdata_nxt[LIC_LOSS_W-1:0] = loss_s;
         LIC_OFS_IRQ_STAT_A: rdata_nxt[LIC_EQ_BIT] = equalizer_irq_flag_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= rdata_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // line-side control decode
   logic [2:0] tx_term;
   logic [2:0] rx_term;
   logic tx_int_nxt;
   logic rx_int_nxt;
   logic [3:0] prof_nxt;
   logic [1:0] rx_code_nxt;
   logic pd_nxt;
   logic hiz_nxt;
   logic [1:0] gain_nxt;
   logic eq_en_nxt;
   logic haul_nxt;

   assign tx_term = imp_r[LIC_TX_TERM_LSB +: 3];
   assign rx_term = imp_r[LIC_RX_TERM_LSB +: 3];

   // external transmit match under T1/J1 is guarded only under pin control; in register mode software owns it
   always_comb
   begin
      if (hw_s)
      begin
         rx_int_nxt = ~imp_pin_s;
         tx_int_nxt = ~imp_pin_s | i_t1_mode;
         prof_nxt = prof_s;
         rx_code_nxt = 2'h0;
         pd_nxt = (txfn_s == LIC_TXFN_OFF);
         gain_nxt = gain_pin_s ? LIC_GAIN_26DB : LIC_GAIN_0DB;
         haul_nxt = haul_s;
         eq_en_nxt = haul_s;
      end
      else
      begin
         tx_int_nxt = ~tx_term[LIC_TERM_EXT_BIT];
         prof_nxt = term_to_profile(tx_term[1:0]);
         rx_int_nxt = ~rx_term[LIC_TERM_EXT_BIT];
         rx_code_nxt = rx_term[1:0];
         pd_nxt = tx_cfg_a_r[LIC_TX_OFF_BIT];
         gain_nxt = rx_cfg_c_r[LIC_MON_GAIN_LSB +: 2];
         haul_nxt = rx_cfg_b_r[LIC_LONG_HAUL_BIT];
         eq_en_nxt = rx_cfg_b_r[LIC_EQ_ENABLE_BIT];
      end
      // the driver bit floats the pins only; transmit logic is left running
      hiz_nxt = hiz_pin_s | (~hw_s & tx_cfg_b_r[LIC_DRV_HIZ_BIT]);
      hiz_nxt = hiz_nxt | pd_nxt | reset_hiz_r | mclk_lost_s;
      hiz_nxt = hiz_nxt | (tclk_lost_s & ~(i_remote_loopback | i_tx_pattern_mclk));
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_tx_internal_match <= 1'b1;
         o_tx_profile <= 4'h0;
         o_rx_internal_match <= 1'b1;
         o_rx_impedance_code <= 2'h0;
         o_tx_power_down <= 1'b0;
         o_tx_hiz <= 1'b1;
         o_monitor_gain_sel <= LIC_GAIN_0DB;
         o_equalizer_enable <= 1'b0;
         o_long_haul <= 1'b0;
         o_obs_period <= LIC_OBS_128;
         o_eq_irq <= 1'b0;
      end
      else
      begin
         o_tx_internal_match <= tx_int_nxt;
         o_tx_profile <= prof_nxt;
         o_rx_internal_match <= rx_int_nxt;
         o_rx_impedance_code <= rx_code_nxt;
         o_tx_power_down <= pd_nxt;
         o_tx_hiz <= hiz_nxt;
         o_monitor_gain_sel <= gain_nxt;
         o_equalizer_enable <= eq_en_nxt;
         o_long_haul <= haul_nxt;
         o_obs_period <= window_to_period(rx_cfg_c_r[LIC_OBS_WIN_LSB +: 2]);
         o_eq_irq <= equalizer_irq_flag_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_tx_int_match: assert property (!hw_s && !tx_term[2] |=> o_tx_internal_match)
      else $error("internal transmit match not selected");
   a_rx_ext_match: assert property (!hw_s && rx_term[2] |=> !o_rx_internal_match)
      else $error("receive match not external");
   a_hw_t1_split: assert property (hw_s && imp_pin_s && i_t1_mode
      |=> !o_rx_internal_match && o_tx_internal_match)
      else $error("hardware T1 split wrong");
   a_hiz_pin_float: assert property (hiz_pin_s |=> o_tx_hiz)
      else $error("global pin did not float drivers");
   a_tclk_loss_float: assert property (tclk_lost_s && !i_remote_loopback
      && !i_tx_pattern_mclk |=> o_tx_hiz)
      else $error("transmit clock loss did not float drivers");
   a_txoff_float: assert property (!hw_s && tx_cfg_a_r[LIC_TX_OFF_BIT]
      |=> o_tx_power_down && o_tx_hiz)
      else $error("power-down did not float drivers");
   a_hw_txfn_off: assert property (hw_s && txfn_s == LIC_TXFN_OFF |=> o_tx_power_down)
      else $error("function pins did not power down");
   a_hw_gain_pin: assert property (hw_s && gain_pin_s |=> o_monitor_gain_sel == 2'h2)
      else $error("hardware gain not 26 dB");
   a_rise_sets_flag: assert property (!range_d_r && range_s && !irq_mask_r[7]
      && !i_soft_reset |=> ##1 o_eq_irq)
      else $error("rising range flag lost");
   a_fall_ignored: assert property (!edge_sel_r[7] && range_d_r && !range_s && !equalizer_irq_flag_r
      |=> !equalizer_irq_flag_r)
      else $error("falling edge set flag with edge select 0");
   a_any_edge_sets: assert property (edge_sel_r[7] && $changed(range_s) && range_d_r != range_s
      && !irq_mask_r[7] && !i_soft_reset |=> equalizer_irq_flag_r)
      else $error("change did not set flag");
   a_read_clears: assert property (eq_clr && !eq_set |=> !equalizer_irq_flag_r)
      else $error("read did not clear flag");

   c_rise_irq: cover property (!range_d_r && range_s ##1 equalizer_irq_flag_r ##[1:4] eq_clr);
   c_hw_power_down: cover property (hw_s && txfn_s == LIC_TXFN_OFF ##1 o_tx_hiz);
   c_sw_release: cover property (reset_hiz_r ##1 !reset_hiz_r ##1 !o_tx_hiz);
endmodule
`default_nettype wire

// ==== bench/lic_line_model.sv ====
// line-side partner: equaliser range and cable loss as seen by the receiver
`timescale 1ns/10ps
`default_nettype none
module lic_line_model (
   // clock
   input wire logic i_clk,
   // requests from the bench
   input wire logic i_range_req,
   input wire logic [4:0] i_loss_req,
   input wire logic i_slow,
   // towards the block
   output logic o_range,
   output logic [4:0] o_loss
);
   int wait_cnt = 0;
   initial o_range = 1'b0;
   initial o_loss = 5'h00;
   // slow mode lags each change by a few cycles, like an equaliser still settling
   always @(posedge i_clk)
   begin
      if (i_range_req !== o_range || i_loss_req !== o_loss)
      begin
         if (!i_slow || wait_cnt >= 3)
         begin
            o_range <= i_range_req;
            o_loss <= i_loss_req;
            wait_cnt <= 0;
         end
         else
            wait_cnt <= wait_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ==== bench/test_line_interface_control.sv ====
// self-checking bench for the line interface control block
`timescale 1ns/10ps
`default_nettype none
module test_line_interface_control;
   import lic_pkg::*;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_soft_reset = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_t1_mode = 1'b0, i_remote_loopback = 1'b0, i_tx_pattern_mclk = 1'b0;
   logic i_hw_mode = 1'b0, i_hw_impedance_pin = 1'b0, i_hw_monitor_gain_pin = 1'b0;
   logic i_hw_haul_select_pin = 1'b0, i_driver_hiz_ctl = 1'b0;
   logic [3:0] i_hw_line_profile_pins = 4'h0;
   logic [1:0] i_hw_tx_function_pins = 2'h0;
   logic i_mclk_lost = 1'b0, i_tclk_lost = 1'b0, range_req = 1'b0, slow = 1'b0;
   logic [4:0] loss_req = 5'h00;
   wire logic range_in;
   wire logic [4:0] loss_in;
   logic [7:0] o_reg_rdata;
   logic o_tx_internal_match, o_rx_internal_match, o_tx_hiz, o_tx_power_down;
   logic o_equalizer_enable, o_long_haul, o_eq_irq;
   logic [3:0] o_tx_profile;
   logic [1:0] o_rx_impedance_code, o_monitor_gain_sel;
   logic [8:0] o_obs_period;
   int miscompares = 0, total_checks = 0, seed = 32'hf7ac14f2;
   // behavioural model of the register state
   int m_term, m_txa, m_drv, m_rxb, m_rxc, m_edge, m_mask, m_flag, m_hold;

   always #5 i_clk = ~i_clk;

   lic_line_model line (.i_clk(i_clk), .i_range_req(range_req), .i_loss_req(loss_req),
      .i_slow(slow), .o_range(range_in), .o_loss(loss_in));

   lic_line_ctrl uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_soft_reset(i_soft_reset),
      .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_t1_mode(i_t1_mode),
      .i_remote_loopback(i_remote_loopback), .i_tx_pattern_mclk(i_tx_pattern_mclk),
      .i_hw_mode(i_hw_mode), .i_hw_impedance_pin(i_hw_impedance_pin),
      .i_hw_line_profile_pins(i_hw_line_profile_pins),
      .i_hw_tx_function_pins(i_hw_tx_function_pins),
      .i_hw_monitor_gain_pin(i_hw_monitor_gain_pin),
      .i_hw_haul_select_pin(i_hw_haul_select_pin), .i_driver_hiz_ctl(i_driver_hiz_ctl),
      .i_mclk_lost(i_mclk_lost), .i_tclk_lost(i_tclk_lost), .i_equalizer_range_in(range_in),
      .i_cable_loss_in(loss_in), .o_tx_internal_match(o_tx_internal_match),
      .o_tx_profile(o_tx_profile), .o_rx_internal_match(o_rx_internal_match),
      .o_rx_impedance_code(o_rx_impedance_code), .o_tx_hiz(o_tx_hiz),
      .o_tx_power_down(o_tx_power_down), .o_monitor_gain_sel(o_monitor_gain_sel),
      .o_equalizer_enable(o_equalizer_enable), .o_long_haul(o_long_haul),
      .o_obs_period(o_obs_period), .o_eq_irq(o_eq_irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic model_reset();
      {m_term, m_txa, m_drv, m_rxb, m_edge, m_mask, m_flag} = '0;
      m_rxc = 8;
      m_hold = 1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      case (a)
         LIC_OFS_IMPEDANCE: m_term = d;
         LIC_OFS_TX_CFG_A: m_txa = d;
         LIC_OFS_TX_CFG_B: {m_drv, m_hold} = {32'(d), 32'd0};
         LIC_OFS_RX_CFG_B: m_rxb = d;
         LIC_OFS_RX_CFG_C: m_rxc = d;
         LIC_OFS_IRQ_MASK: m_mask = d;
         LIC_OFS_EDGE_SEL: m_edge = d;
         default: ;
      endcase
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1;
      check(9'(o_reg_rdata), 9'(exp));
   endtask

   // compares match, power-down, float, gain and interrupt outputs with the model once async pins have settled; profile in both modes, the rest in one mode
   task automatic check_all();
      int tx_int, rx_int, pd;
      repeat (4) @(posedge i_clk);
      #1;
      if (i_hw_mode)
      begin
         tx_int = !i_hw_impedance_pin || i_t1_mode;
         rx_int = !i_hw_impedance_pin;
         pd = (i_hw_tx_function_pins == LIC_TXFN_OFF);
         check(9'(o_monitor_gain_sel), i_hw_monitor_gain_pin ? 9'(LIC_GAIN_26DB) : 9'h0);
         check(9'(o_long_haul), 9'(i_hw_haul_select_pin));
         if (tx_int)
            check(9'(o_tx_profile), 9'(i_hw_line_profile_pins));
      end
      else
      begin
         tx_int = !m_term[2];
         rx_int = !m_term[5];
         pd = m_txa[4];
         check(9'(o_monitor_gain_sel), 9'(m_rxc & 3));
         check(o_obs_period, 9'(32 << ((m_rxc >> 2) & 3)));
         check(9'(o_equalizer_enable), 9'(m_rxb[6]));
         if (tx_int)
            check(9'(o_tx_profile), 9'((m_term & 3) == 3 ? 7 : m_term & 3));
         if (rx_int)
            check(9'(o_rx_impedance_code), 9'((m_term >> 3) & 3));
      end
      check(9'(o_tx_internal_match), 9'(tx_int));
      check(9'(o_rx_internal_match), 9'(rx_int));
      check(9'(o_tx_power_down), 9'(pd));
      check(9'(o_tx_hiz), 9'(pd | i_driver_hiz_ctl | i_mclk_lost
         | (i_tclk_lost & !(i_remote_loopback | i_tx_pattern_mclk))
         | (!i_hw_mode & (m_hold | m_drv[5]))));
      check(9'(o_eq_irq), 9'(m_flag));
   endtask

   task automatic set_range(input logic v);
      @(posedge i_clk);
      if (!m_mask[7] && v != range_req && (m_edge[7] || v))
         m_flag = 1;
      range_req <= v;
      repeat (8) @(posedge i_clk);
      check_all();
      rd(LIC_OFS_STATUS_A, {v, 7'h00});
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      model_reset();
      repeat (6) @(posedge i_clk);
      i_arst_n <= 1'b1;
      check_all();
      rd(8'h30, 8'h00);
      wr(LIC_OFS_TX_CFG_B, 8'h00);
      for (int i = 0; i < 64; i++)
      begin
         // t1 mode is low here, so an external transmit match is a legal pick
         wr(LIC_OFS_IMPEDANCE, 8'(i));
         check_all();
      end
      for (int i = 0; i < 16; i++)
      begin
         wr(LIC_OFS_RX_CFG_C, 8'(i));
         check_all();
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(LIC_OFS_RX_CFG_B, 8'(i << 5));
         wr(LIC_OFS_TX_CFG_B, 8'(i << 5));
         wr(LIC_OFS_TX_CFG_A, 8'(i << 3));
         check_all();
      end
      wr(LIC_OFS_TX_CFG_A, 8'h00);
      // a left-over float bit would mask every pin-driven float below
      wr(LIC_OFS_TX_CFG_B, 8'h00);
      for (int i = 0; i < 32; i++)
      begin
         @(posedge i_clk);
         {i_driver_hiz_ctl, i_mclk_lost, i_tclk_lost, i_remote_loopback,
            i_tx_pattern_mclk} <= i[4:0];
         check_all();
      end
      @(posedge i_clk);
      {i_driver_hiz_ctl, i_mclk_lost, i_tclk_lost} <= 3'h0;
      {i_remote_loopback, i_tx_pattern_mclk} <= 2'h0;
      for (int e = 0; e < 2; e++)
      begin
         wr(LIC_OFS_EDGE_SEL, 8'(e << 7));
         for (int k = 0; k < 2; k++)
         begin
            set_range(!k[0]);
            rd(LIC_OFS_IRQ_STAT_A, 8'(m_flag << 7));
            m_flag = 0;
            check_all();
         end
      end
      wr(LIC_OFS_IRQ_MASK, 8'h80);
      set_range(1'b1);
      set_range(1'b0);
      wr(LIC_OFS_IRQ_MASK, 8'h00);
      slow <= 1'b1;
      set_range(1'b1);
      rd(LIC_OFS_IRQ_STAT_A, 8'h80);
      m_flag = 0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clk);
         loss_req <= 5'($random(seed));
         repeat (12) @(posedge i_clk);
         rd(LIC_OFS_STATUS_B, 8'(loss_req));
      end
      wr(LIC_OFS_IMPEDANCE, 8'h00);
      @(posedge i_clk);
      i_hw_mode <= 1'b1;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge i_clk);
         {i_t1_mode, i_hw_impedance_pin, i_hw_monitor_gain_pin, i_hw_haul_select_pin,
            i_hw_tx_function_pins} <= i[5:0];
         i_hw_line_profile_pins <= 4'(i % 12);
         check_all();
      end
      @(posedge i_clk);
      i_hw_mode <= 1'b0;
      i_t1_mode <= 1'b0;
      wr(LIC_OFS_RX_CFG_C, 8'h0f);
      @(posedge i_clk);
      i_soft_reset <= 1'b1;
      @(posedge i_clk);
      i_soft_reset <= 1'b0;
      model_reset();
      check_all();
      report_and_stop();
   end
endmodule
`default_nettype wire
